// ===== hw/tfs_pkg.sv
// Package for the temperature fault supervisor: command codes, field
// layout of the fault action byte, reset values and the response states.
// Assumes a PMBus command layer that presents decoded command accesses.
package tfs_pkg;

	// Command codes of the supervisor's registers.
	localparam logic [7:0] TFS_CMD_HI_FAULT_THR = 8'h4F;
	localparam logic [7:0] TFS_CMD_HI_FAULT_ACT = 8'h50;
	localparam logic [7:0] TFS_CMD_HI_WARN_THR  = 8'h51;
	localparam logic [7:0] TFS_CMD_LO_WARN_THR  = 8'h52;
	localparam logic [7:0] TFS_CMD_LO_FAULT_THR = 8'h53;
	localparam logic [7:0] TFS_CMD_LO_FAULT_ACT = 8'h54;

	// Field positions inside a fault action byte.
	localparam int TFS_MODE_HI  = 7;
	localparam int TFS_MODE_LO  = 6;
	localparam int TFS_RETRY_HI = 5;
	localparam int TFS_RETRY_LO = 3;
	localparam int TFS_DELAY_HI = 2;
	localparam int TFS_DELAY_LO = 0;

	// Response modes.
	localparam logic [1:0] TFS_MODE_IGNORE = 2'h0;
	localparam logic [1:0] TFS_MODE_CONT   = 2'h1;
	localparam logic [1:0] TFS_MODE_OFF    = 2'h2;
	localparam logic [1:0] TFS_MODE_HOLD   = 2'h3;
	localparam logic [2:0] TFS_NO_RETRY    = 3'h0;

	// Reset values, limits in the linear numeric format.
	localparam logic [7:0]  TFS_RST_ACT         = 8'h80;
	localparam logic [15:0] TFS_RST_HI_FAULT    = 16'h007D;
	localparam logic [15:0] TFS_RST_HI_WARN     = 16'h0069;
	localparam logic [15:0] TFS_RST_LO_WARN     = 16'h07E7;
	localparam logic [15:0] TFS_RST_LO_FAULT    = 16'h07D8;

	// Linear format conversion: fixed point with this many fraction bits.
	localparam logic [5:0]  TFS_FRAC_BITS       = 6'h10;

	// Status bit positions.
	localparam int TFS_ST_HI_FAULT = 0;
	localparam int TFS_ST_HI_WARN  = 1;
	localparam int TFS_ST_LO_WARN  = 2;
	localparam int TFS_ST_LO_FAULT = 3;
	localparam int TFS_ST_W        = 4;

	// Channel numbers of the two fault responders.
	localparam int TFS_CH_HI = 0;
	localparam int TFS_CH_LO = 1;

	typedef enum logic [2:0] {
		TFS_RUN,
		TFS_CONT,
		TFS_WAIT,
		TFS_HOLD,
		TFS_LATCH
	} tfs_state_e;

endpackage

// ===== hw/tfs_supervisor.sv
// Temperature fault supervisor: limit and action registers, comparison of
// each temperature reading against them, and the fault response engine.
// Assumes a command layer on the same clock, a reading source on the same
// clock, and the time unit length supplied from its own register.
//
// Functional notes
// R1: Mode 00 keeps output running on fault.
// R2: Mode 01 runs for delay, then retries.
// R3: Mode 10 disables at once, then retries.
// R4: Mode 11 holds off until fault clears.
// R5: Retry 000 latches output off until cleared.
// R6: Nonzero retry field counts restart attempts.
// R7: Delay code n gives two-to-n units.
// R8: Delay used for run time and retry gap.
// R9: Unit length comes from separate register.
// R10: Any fault drives alert low, sets status.
// R11: High fault action byte at command 50.
// R12: High fault threshold at command 4F.
// R13: High warning threshold at command 51.
// R14: Low warning threshold at command 52.
// R15: Low fault threshold at command 53.
// R16: Low fault action at 54, same fields.
// R17: Readings compared against warning thresholds.
`timescale 1ns/100ps

module tfs_supervisor
#(
	parameter int UNIT_W = 16
)
(
	input  wire logic              core_clk_i,         // 10 MHz clock
	input  wire logic              rst_b_i,            // Async reset, low
	input  wire logic              cmd_valid_i,        // Command access
	input  wire logic              cmd_write_i,        // 1 write, 0 read
	input  wire logic [7:0]        cmd_code_i,         // Command code
	input  wire logic [15:0]       cmd_wdata_i,        // Write data
	output logic      [15:0]       cmd_rdata_o,        // Read data
	output logic                   cmd_ack_o,          // Access accepted
	output logic                   cmd_nack_o,         // Unknown code
	input  wire logic              temp_valid_i,       // New reading
	input  wire logic [15:0]       temp_i,             // Reading, linear
	input  wire logic [UNIT_W-1:0] unit_cycles_i,      // Cycles per unit
	input  wire logic              clear_faults_i,     // Clear status
	output logic                   output_enable_o,    // Converter on
	output logic                   alert_n_o,          // Alert, low
	output logic [tfs_pkg::TFS_ST_W-1:0] status_o      // Sticky flags
);

	import tfs_pkg::*;

	// Linear format word to signed fixed point with sixteen fraction bits.
	function automatic logic signed [47:0] lin_val(input logic [15:0] w);
		logic signed [47:0] m;
		logic [5:0]         sh;
		m  = {{37{w[10]}}, w[10:0]};
		sh = 6'({w[15], w[15:11]} + TFS_FRAC_BITS);
		lin_val = m <<< sh;
	endfunction

	logic [7:0]  hi_act_r;
	logic [7:0]  lo_act_r;
	logic [15:0] hi_fault_thr_r;
	logic [15:0] hi_warn_thr_r;
	logic [15:0] lo_warn_thr_r;
	logic [15:0] lo_fault_thr_r;
	logic [15:0] rdata_nxt;
	logic        hit;

	wire wr = cmd_valid_i && cmd_write_i;

	// R11 R12 R13 R14 R15 R16: command decode
	wire wr_hi_act   = wr && cmd_code_i == TFS_CMD_HI_FAULT_ACT;
	wire wr_lo_act   = wr && cmd_code_i == TFS_CMD_LO_FAULT_ACT;
	wire wr_hi_fault = wr && cmd_code_i == TFS_CMD_HI_FAULT_THR;
	wire wr_hi_warn  = wr && cmd_code_i == TFS_CMD_HI_WARN_THR;
	wire wr_lo_warn  = wr && cmd_code_i == TFS_CMD_LO_WARN_THR;
	wire wr_lo_fault = wr && cmd_code_i == TFS_CMD_LO_FAULT_THR;

	always_comb
	begin
		hit       = 1'b1;
		rdata_nxt = 16'h0000;
		unique case (cmd_code_i)
			TFS_CMD_HI_FAULT_THR: rdata_nxt = hi_fault_thr_r;
			TFS_CMD_HI_FAULT_ACT: rdata_nxt = {8'h00, hi_act_r};
			TFS_CMD_HI_WARN_THR:  rdata_nxt = hi_warn_thr_r;
			TFS_CMD_LO_WARN_THR:  rdata_nxt = lo_warn_thr_r;
			TFS_CMD_LO_FAULT_THR: rdata_nxt = lo_fault_thr_r;
			TFS_CMD_LO_FAULT_ACT: rdata_nxt = {8'h00, lo_act_r};
			default:              hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			hi_act_r       <= TFS_RST_ACT;
			lo_act_r       <= TFS_RST_ACT;
			hi_fault_thr_r <= TFS_RST_HI_FAULT;
			hi_warn_thr_r  <= TFS_RST_HI_WARN;
			lo_warn_thr_r  <= TFS_RST_LO_WARN;
			lo_fault_thr_r <= TFS_RST_LO_FAULT;
		end
		else
		begin
			if (wr_hi_act)
				hi_act_r <= cmd_wdata_i[7:0];
			if (wr_lo_act)
				lo_act_r <= cmd_wdata_i[7:0];
			if (wr_hi_fault)
				hi_fault_thr_r <= cmd_wdata_i;
			if (wr_hi_warn)
				hi_warn_thr_r <= cmd_wdata_i;
			if (wr_lo_warn)
				lo_warn_thr_r <= cmd_wdata_i;
			if (wr_lo_fault)
				lo_fault_thr_r <= cmd_wdata_i;
		end
	end

	// Reads return the value held at the access; write accesses return zero.
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cmd_rdata_o <= 16'h0000;
			cmd_ack_o   <= 1'b0;
			cmd_nack_o  <= 1'b0;
		end
		else
		begin
			cmd_ack_o   <= cmd_valid_i && hit;
			cmd_nack_o  <= cmd_valid_i && !hit;
			cmd_rdata_o <= (cmd_valid_i && !cmd_write_i) ? rdata_nxt
			                                             : 16'h0000;
		end
	end

	// Comparison of each reading; levels hold until the next reading.
	logic [TFS_ST_W-1:0] level_r;
	logic [TFS_ST_W-1:0] level_nxt;
	logic [TFS_ST_W-1:0] status_nxt;

	wire logic signed [47:0] t_val = lin_val(temp_i);

	always_comb
	begin
		level_nxt = level_r;
		if (temp_valid_i)
		begin
			level_nxt[TFS_ST_HI_FAULT] = t_val > lin_val(hi_fault_thr_r);
			// R17: warning compares
			level_nxt[TFS_ST_HI_WARN]  = t_val > lin_val(hi_warn_thr_r);
			level_nxt[TFS_ST_LO_WARN]  = t_val < lin_val(lo_warn_thr_r);
			level_nxt[TFS_ST_LO_FAULT] = t_val < lin_val(lo_fault_thr_r);
		end
	end

	// R10: sticky status, set wins over clear
	assign status_nxt = (status_o & ~{TFS_ST_W{clear_faults_i}}) | level_r;

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			level_r   <= '0;
			status_o  <= '0;
			alert_n_o <= 1'b1;
		end
		else
		begin
			level_r   <= level_nxt;
			status_o  <= status_nxt;
			// R10: alert pulled low
			alert_n_o <= ~|status_nxt;
		end
	end

	// R9: time unit divider, length from the separate unit register
	logic [UNIT_W-1:0] unit_cnt_r;
	logic              unit_tick_r;

	wire unit_end = unit_cnt_r + 1'b1 >= unit_cycles_i;

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			unit_cnt_r  <= '0;
			unit_tick_r <= 1'b0;
		end
		else
		begin
			unit_cnt_r  <= unit_end ? '0 : unit_cnt_r + 1'b1;
			unit_tick_r <= unit_end;
		end
	end

	// Fault response engines, one per fault channel.
	tfs_state_e st_r   [2];
	tfs_state_e st_nxt [2];
	logic [7:0] tmr_r  [2];
	logic [7:0] tmr_nxt[2];
	logic [2:0] left_r [2];
	logic [2:0] left_nxt[2];
	logic [1:0] run_ok;

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_ch
			wire [7:0] act   = (g == TFS_CH_LO) ? lo_act_r : hi_act_r;
			wire       flt   = (g == TFS_CH_LO) ? level_r[TFS_ST_LO_FAULT]
			                                    : level_r[TFS_ST_HI_FAULT];
			wire [1:0] mode  = act[TFS_MODE_HI:TFS_MODE_LO];
			wire [2:0] retry = act[TFS_RETRY_HI:TFS_RETRY_LO];
			// R7: power-of-two delay decode
			wire [7:0] load  = 8'h01 << act[TFS_DELAY_HI:TFS_DELAY_LO];
			wire       done  = unit_tick_r && tmr_r[g] == 8'h01;

			always_comb
			begin
				st_nxt[g]   = st_r[g];
				tmr_nxt[g]  = tmr_r[g];
				left_nxt[g] = left_r[g];
				if (unit_tick_r && tmr_r[g] != 8'h00)
					tmr_nxt[g] = tmr_r[g] - 8'h01;
				unique case (st_r[g])
					TFS_RUN:
						if (flt)
						begin
							unique case (mode)
								// R1: ignore fault
								TFS_MODE_IGNORE: st_nxt[g] = TFS_RUN;
								// R2 R8: continue for the delay
								TFS_MODE_CONT:
								begin
									st_nxt[g]  = TFS_CONT;
									tmr_nxt[g] = load;
								end
								// R3 R5: disable at once
								TFS_MODE_OFF:
								begin
									st_nxt[g]   = (retry == TFS_NO_RETRY)
									              ? TFS_LATCH : TFS_WAIT;
									tmr_nxt[g]  = load;
									left_nxt[g] = retry;
								end
								// R4: hold while fault persists
								TFS_MODE_HOLD: st_nxt[g] = TFS_HOLD;
							endcase
						end
					TFS_CONT:
						if (!flt)
							st_nxt[g] = TFS_RUN;
						// R2 R5: fault outlasted the delay
						else if (done)
						begin
							st_nxt[g]   = (retry == TFS_NO_RETRY)
							              ? TFS_LATCH : TFS_WAIT;
							tmr_nxt[g]  = load;
							left_nxt[g] = retry;
						end
					TFS_WAIT:
						// R6 R8: restart attempt after each gap
						if (done)
						begin
							if (!flt)
								st_nxt[g] = TFS_RUN;
							else if (left_r[g] == 3'h1)
								st_nxt[g] = TFS_LATCH;
							else
							begin
								left_nxt[g] = left_r[g] - 3'h1;
								tmr_nxt[g]  = load;
							end
						end
					// R4: resume when fault gone
					TFS_HOLD:
						if (!flt)
							st_nxt[g] = TFS_RUN;
					// R5: stay off until cleared
					TFS_LATCH:
						if (clear_faults_i && !flt)
							st_nxt[g] = TFS_RUN;
				endcase
			end

			always_ff @(posedge core_clk_i or negedge rst_b_i)
			begin
				if (!rst_b_i)
				begin
					st_r[g]   <= TFS_RUN;
					tmr_r[g]  <= 8'h00;
					left_r[g] <= 3'h0;
				end
				else
				begin
					st_r[g]   <= st_nxt[g];
					tmr_r[g]  <= tmr_nxt[g];
					left_r[g] <= left_nxt[g];
				end
			end

			assign run_ok[g] = st_nxt[g] == TFS_RUN || st_nxt[g] == TFS_CONT;
		end
	endgenerate

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			output_enable_o <= 1'b1;
		else
			output_enable_o <= &run_ok;
	end

endmodule

// ===== verification/tfs_host_model.sv
// Host model: issues one command access per clock.
// Assumes calls start just after a rising clock edge.
`timescale 1ns/100ps
module tfs_host_model
(
	input  wire logic	core_clk_i,	// clock
	output logic		cmd_valid_o,	// req
	output logic		cmd_write_o,	// dir
	output logic [7:0]	cmd_code_o,	// code
	output logic [15:0]	cmd_wdata_o	// data
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_code_o = 8'h00;
		cmd_wdata_o = 16'h0000;
	end
	// Back-to-back calls keep valid high across edges.
	task automatic acc(input logic w, input logic [7:0] c,
		input logic [15:0] d);
		cmd_valid_o = 1'b1;
		cmd_write_o = w;
		cmd_code_o = c;
		cmd_wdata_o = d;
		@(posedge core_clk_i);
		#1;
	endtask
	// Released code and data are inverted so stale values never look valid.
	task automatic idle();
		cmd_valid_o = 1'b0;
		cmd_code_o = ~cmd_code_o;
		cmd_wdata_o = ~cmd_wdata_o;
		@(posedge core_clk_i);
		#1;
	endtask
endmodule

// ===== verification/tfs_supervisor_properties.sv
// Checker for the supervisor's ports.
// Assumes it is bound into every tfs_supervisor instance.
`timescale 1ns/100ps
module tfs_props
#(parameter int UNIT_W = 16)
(
	input wire logic			core_clk_i,	// clk
	input wire logic			rst_b_i,	// rst
	input wire logic			cmd_valid_i,	// req
	input wire logic			cmd_write_i,	// dir
	input wire logic [7:0]			cmd_code_i,	// code
	input wire logic [15:0]			cmd_wdata_i,	// data
	input wire logic [15:0]			cmd_rdata_o,	// rdata
	input wire logic			cmd_ack_o,	// ack
	input wire logic			cmd_nack_o,	// nack
	input wire logic			temp_valid_i,	// rdg
	input wire logic [15:0]			temp_i,		// temp
	input wire logic [UNIT_W-1:0]		unit_cycles_i,	// unit
	input wire logic			clear_faults_i,	// clr
	input wire logic			output_enable_o,// on
	input wire logic			alert_n_o,	// alert
	input wire logic [tfs_pkg::TFS_ST_W-1:0]	status_o	// flags
);
	import tfs_pkg::*;
	logic [7:0]	hi_act_r;
	wire [1:0]	hi_mode = hi_act_r[7:6];
	wire		hit = cmd_code_i >= TFS_CMD_HI_FAULT_THR
				&& cmd_code_i <= TFS_CMD_LO_FAULT_ACT;
	wire		lo_ok = !status_o[TFS_ST_LO_FAULT];
	// Shadow of the high action byte, to know the active mode.
	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			hi_act_r <= TFS_RST_ACT;
		else if (cmd_valid_i && cmd_write_i
			&& cmd_code_i == TFS_CMD_HI_FAULT_ACT)
			hi_act_r <= cmd_wdata_i[7:0];
	end
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	a_ack_mapped: assert property (cmd_valid_i && hit |=> cmd_ack_o
		&& !cmd_nack_o) else $error("no ack");
	a_nack_unmapped: assert property (cmd_valid_i && !hit |=>
		cmd_nack_o && !cmd_ack_o && cmd_rdata_o == 16'h0000)
		else $error("no nack");
	a_alert_status: assert property (alert_n_o == (status_o == 4'h0))
		else $error("alert wrong");
	a_status_sticky: assert property (!clear_faults_i |=>
		($past(status_o) & ~status_o) == 4'h0) else $error("flag lost");
	a_ignore_runs: assert property (hi_mode == TFS_MODE_IGNORE && lo_ok
		&& output_enable_o |=> output_enable_o || !lo_ok)
		else $error("stopped");
	a_off_at_once: assert property (hi_mode == TFS_MODE_OFF
		&& $rose(status_o[0]) |-> !output_enable_o) else $error("still on");
	a_cont_keeps: assert property (hi_mode == TFS_MODE_CONT && lo_ok
		&& $rose(status_o[0]) |-> output_enable_o) else $error("off early");
	a_latch_held: assert property (hi_act_r[7:3] == 5'h10 && lo_ok
		&& !output_enable_o && !clear_faults_i && !$past(clear_faults_i)
		&& !$past(clear_faults_i, 2) |=> !output_enable_o)
		else $error("unlatched");
	c_cont: cover property (hi_mode == TFS_MODE_CONT && $rose(status_o[0]));
	c_nack: cover property (cmd_nack_o);
	c_lo: cover property ($rose(status_o[TFS_ST_LO_FAULT]));
endmodule
bind tfs_supervisor tfs_props #(.UNIT_W(UNIT_W)) u_props (
	.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
	.cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i),
	.cmd_wdata_i(cmd_wdata_i), .cmd_rdata_o(cmd_rdata_o),
	.cmd_ack_o(cmd_ack_o), .cmd_nack_o(cmd_nack_o),
	.temp_valid_i(temp_valid_i), .temp_i(temp_i),
	.unit_cycles_i(unit_cycles_i), .clear_faults_i(clear_faults_i),
	.output_enable_o(output_enable_o), .alert_n_o(alert_n_o),
	.status_o(status_o));

// ===== verification/tb_top.sv
// Bench for tfs_supervisor: register access, readings and fault modes.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/100ps
module tb_top;
	import tfs_pkg::*;
	logic		core_clk_i = 1'b0;
	logic		rst_b_i = 1'b0;
	logic		cmd_valid, cmd_write, cmd_ack, cmd_nack, oe, alert_n;
	logic		temp_valid = 1'b0, clear = 1'b0;
	logic [7:0]	cmd_code;
	logic [15:0]	cmd_wdata, cmd_rdata, d, temp = 16'h0000;
	logic [15:0]	unit = 16'h0001;
	logic [3:0]	status;
	logic [17:0]	e;
	logic [17:0]	q[$];
	int		fails = 0, n_compared = 0, cyc = 0, i, u;
	logic [15:0]	rv [7] = '{TFS_RST_HI_FAULT, {8'h00, TFS_RST_ACT},
		TFS_RST_HI_WARN, TFS_RST_LO_WARN, TFS_RST_LO_FAULT,
		{8'h00, TFS_RST_ACT}, 16'h0000};
	always #50 core_clk_i = ~core_clk_i;
	tfs_host_model host (.core_clk_i(core_clk_i), .cmd_valid_o(cmd_valid),
		.cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
		.cmd_wdata_o(cmd_wdata));
	tfs_supervisor #(.UNIT_W(16)) uut (.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid),
		.cmd_write_i(cmd_write), .cmd_code_i(cmd_code),
		.cmd_wdata_i(cmd_wdata), .cmd_rdata_o(cmd_rdata),
		.cmd_ack_o(cmd_ack), .cmd_nack_o(cmd_nack),
		.temp_valid_i(temp_valid), .temp_i(temp), .unit_cycles_i(unit),
		.clear_faults_i(clear), .output_enable_o(oe),
		.alert_n_o(alert_n), .status_o(status));
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic rst();
		rst_b_i = 1'b0;
		tk(8);
		rst_b_i = 1'b1;
	endtask
	task automatic bad(input logic [16:0] g, input logic [16:0] x);
		fails++;
		$display("mismatch t=%0t got %h exp %h", $time, g, x);
	endtask
	task automatic chk_cmd(input logic [16:0] g, input logic [16:0] x);
		n_compared++;
		if (g !== x)
			bad(g, x);
	endtask
	task automatic chk_pin(input logic on, input logic [3:0] st);
		n_compared++;
		if ({oe, alert_n, status} !== {on, st == 4'h0, st})
			bad({oe, alert_n, status}, {on, st == 4'h0, st});
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] v);
		q.push_back(18'h20000);
		host.acc(1'b1, c, v);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] x,
		input logic nk);
		q.push_back({1'b1, nk, x});
		host.acc(1'b0, c, 16'($urandom));
	endtask
	task automatic rdg(input logic [15:0] t);
		temp = t;
		temp_valid = 1'b1;
		tk(1);
		temp_valid = 1'b0;
		temp = ~t;
		tk(2);
	endtask
	task automatic clr();
		clear = 1'b1;
		tk(1);
		clear = 1'b0;
		tk(3);
	endtask
	task automatic start(input logic [7:0] a, input logic [15:0] un);
		rst();
		unit = un;
		wr(TFS_CMD_HI_FAULT_ACT, {8'($urandom), a});
		host.idle();
		rdg(16'h0082);
	endtask
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(negedge core_clk_i)
	begin
		if (cmd_ack === 1'b1 || cmd_nack === 1'b1)
		begin
			e = q.pop_front();
			chk_cmd({cmd_nack, e[17] ? cmd_rdata : e[15:0]}, e[16:0]);
		end
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	initial
	begin
		d = 16'($urandom(32'h04DE10D3));
		rst();
		for (i = 0; i < 7; i++)
			rd(TFS_CMD_HI_FAULT_THR + 8'(i), rv[i], i == 6);
		host.idle();
		for (i = 0; i < 6; i++)
		begin
			d = 16'($urandom);
			wr(TFS_CMD_HI_FAULT_THR + 8'(i), d);
			rd(TFS_CMD_HI_FAULT_THR + 8'(i),
				(i == 1 || i == 5) ? {8'h00, d[7:0]} : d, 1'b0);
		end
		host.idle();
		$display("test regs done");
		start(8'h00, 16'h0001);
		tk(20);
		chk_pin(1'b1, 4'h3);
		start(8'hC0, 16'h0001);
		chk_pin(1'b0, 4'h3);
		clr();
		chk_pin(1'b0, 4'h3);
		rdg(16'h0014);
		chk_pin(1'b1, 4'h3);
		clr();
		chk_pin(1'b1, 4'h0);
		start(8'h80, 16'h0001);
		chk_pin(1'b0, 4'h3);
		rdg(16'h0014);
		tk(20);
		chk_pin(1'b0, 4'h3);
		clr();
		chk_pin(1'b1, 4'h0);
		start(8'h8B, 16'h0001);
		chk_pin(1'b0, 4'h3);
		rdg(16'h0014);
		tk(20);
		chk_pin(1'b1, 4'h3);
		start(8'h93, 16'h0001);
		tk(8);
		chk_pin(1'b0, 4'h3);
		rdg(16'h0014);
		tk(10);
		chk_pin(1'b1, 4'h3);
		start(8'h88, 16'h0002);
		tk(30);
		rdg(16'h0014);
		tk(20);
		chk_pin(1'b0, 4'h3);
		for (u = 1; u < 5; u += 3)
		begin
			start(8'h43, 16'(u));
			tk(7 * u - 3);
			chk_pin(1'b1, 4'h3);
			tk(u + 7);
			chk_pin(1'b0, 4'h3);
		end
		start(8'h4B, 16'h0001);
		tk(10);
		chk_pin(1'b0, 4'h3);
		rdg(16'h0014);
		tk(5);
		chk_pin(1'b1, 4'h3);
		$display("test modes done");
		rst();
		wr(TFS_CMD_LO_FAULT_ACT, 16'h00C0);
		host.idle();
		rdg(16'h07CE);
		chk_pin(1'b0, 4'hC);
		rdg(16'h006E);
		chk_pin(1'b1, 4'hE);
		$display("test faults done");
		end_sim();
	end
endmodule
